// ---- logic/dwrst_cfg.svh ----
// Constants of the watchdog and reset block.
// Assumes inclusion by bare name from the package and modules.
`ifndef DWRST_CFG_SVH
`define DWRST_CFG_SVH
// ------------------------------------------------
// Register map and fields
// ------------------------------------------------
`define DWRST_WDG_OFFSET 12'h0d8
`define DWRST_WDG_RESET 8'hfe
`define DWRST_CTL_POS 0
`define DWRST_SR_POS 1
`define DWRST_T_MSB_POS 2
`define DWRST_T_LSB_POS 7
`define DWRST_CNT_RESET 7'h7f
`define DWRST_CNT_EXPIRE 7'h40
// ------------------------------------------------
// Timing counts, internal clock cycles
// ------------------------------------------------
`define DWRST_PRESCALE 3072
`define DWRST_STRETCH 2048
`endif

// ---- logic/dwrst_pkg.sv ----
// Types shared by the watchdog and reset block.
// Assumes dwrst_cfg.svh on the include path.
package dwrst_pkg;
   `include "dwrst_cfg.svh"

   // Power state, Gray along run-wait-stop
   typedef enum logic [1:0]
   {
      PWR_RUN = 2'h0,
      PWR_WAIT = 2'h1,
      PWR_STOP = 2'h3
   } dwrst_pwr_t;
endpackage : dwrst_pkg

// ---- logic/dwrst_rst_if.sv ----
// Carrier between watchdog core and reset stretcher.
// Assumes one clock domain, pclk.
`timescale 1ns/1ns
`default_nettype none
interface dwrst_rst_if;
   logic fire; // One-cycle watchdog reset request
   logic rst_n; // Stretched internal reset, low active

   modport src
   (
      output fire,
      input rst_n
   );
   modport gen
   (
      input fire,
      output rst_n
   );
endinterface : dwrst_rst_if
`default_nettype wire

// ---- logic/dwrst_sync.sv ----
// Three-flop synchroniser with agreement filter for a pin.
// Assumes an asynchronous level input.
`timescale 1ns/1ns
`default_nettype none
module dwrst_sync
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low active
   input wire logic pin_in, // Asynchronous pin level
   output logic level_out // Filtered level
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic level_reg;
   logic level_next;

   // Only the last two stages are compared; first stage may be metastable
   always_comb
   begin
      sync_next = {sync_reg[1:0], pin_in};
      level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_reg <= 3'h0;
         level_reg <= 1'b0;
      end
      else
      begin
         sync_reg <= sync_next;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;
endmodule : dwrst_sync
`default_nettype wire

// ---- logic/dwrst_stretch.sv ----
// Reset stretcher: holds internal reset for a fixed count.
// Assumes fire is a one-cycle pulse on pclk.
`timescale 1ns/1ns
`default_nettype none
`include "dwrst_cfg.svh"
module dwrst_stretch
#(
   parameter int unsigned STRETCH = `DWRST_STRETCH,
   parameter int unsigned CNT_W = 12
)
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low active
   dwrst_rst_if.gen rst // Request in, stretched reset out
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic done_reg;
   logic done_next;

   // Restart on any request, release after the full count
   always_comb
   begin
      cnt_next = cnt_reg;
      done_next = done_reg;
      if (rst.fire)
      begin
         cnt_next = '0;
         done_next = 1'b0;
      end
      else if (!done_reg)
      begin
         cnt_next = cnt_reg + CNT_W'(1);
         done_next = (cnt_reg == CNT_W'(STRETCH - 1));
      end
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign rst.rst_n = done_reg;
endmodule : dwrst_stretch
`default_nettype wire

// ---- logic/dwrst_top.sv ----
// Digital watchdog with internal reset generation, APB slave.
// Assumes core strobes on pclk; nmi_pin is asynchronous.
//
// Functional notes
// - Missed reload causes internal reset, which also restores the counter.
// - Watchdog reset restarts like pin reset, same stabilisation delay.
// - Internal reset held 2048 cycles after its source releases.
// - Active unreloaded counter keeps decrementing toward zero and resets.
// - Software option: inactive until the activate bit is written one.
// - Once active, deactivation is ignored until device reset.
// - While inactive, STOP enters stop mode normally.
// - Hardware option: watchdog active from reset onward.
// - Hardware option without stop gating: STOP acts as WAIT.
// - Stop gating, NMI low: STOP acts as WAIT, counter runs.
// - Stop gating, NMI high: counter frozen, stop mode entered.
// - Wake interrupt leaves stop; counter resumes from held value.
// - Any reset loads register value fe; the hardware option reads ff.
// - Writing soft-reset bit zero resets at once; software writes one.
// - Count bits reversed: bit 7 is count LSB, bit 2 MSB.
// - Reset fires when counter bit 6 falls from one to zero.
// - Six count bits give 64 periods, 3072 to 196608 cycles.
// - Hardware option: activate bit reads one, not writable.
// - Inactive counter is a free 7-bit timer, never resets.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "dwrst_cfg.svh"
module dwrst_top
#(
   parameter bit OPT_HW_ACT = 1'b0, // Factory option: hardware activation
   parameter bit OPT_EXT_STOP = 1'b0, // Factory option: external stop gating
   parameter int unsigned PRESCALE = `DWRST_PRESCALE,
   parameter int unsigned STRETCH = `DWRST_STRETCH,
   parameter int unsigned PRE_W = 12
)
(
   input wire logic pclk, // Internal clock
   input wire logic presetn, // Pin or power-on reset, low active
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic stop_req, // Core executes STOP, pulse
   input wire logic wait_req, // Core executes WAIT, pulse
   input wire logic wake_irq, // Interrupt wakes the core, pulse
   input wire logic nmi_pin, // Non-maskable interrupt pin level
   output logic mcu_rst_n, // Internal reset, low active
   output logic wdg_active, // Watchdog armed
   output dwrst_pkg::dwrst_pwr_t pwr_state // Run, wait or stop
);
   import dwrst_pkg::*;

   // ------------------------------------------------
   // Declarations
   // ------------------------------------------------
   logic [6:0] cnt_reg;
   logic [6:0] cnt_next;
   logic [PRE_W-1:0] pre_reg;
   logic [PRE_W-1:0] pre_next;
   logic ctl_reg;
   logic ctl_next;
   logic fire_reg;
   logic fire_next;
   logic [31:0] rd_reg;
   logic [31:0] rd_next;
   dwrst_pwr_t pwr_reg;
   dwrst_pwr_t pwr_next;
   logic addr_hit;
   logic wr_hit;
   logic tick;
   logic active;
   logic run_int;
   logic nmi_high;
   logic [6:0] wr_cnt;
   logic [7:0] rd_map;

   dwrst_rst_if rst_if ();

   // ------------------------------------------------
   // Reset stretcher and pin synchroniser
   // ------------------------------------------------
   dwrst_stretch
   #(
      .STRETCH(STRETCH),
      .CNT_W(12)
   )
   u_stretch
   (
      .pclk(pclk),
      .presetn(presetn),
      .rst(rst_if.gen)
   );

   dwrst_sync u_nmi_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(nmi_pin),
      .level_out(nmi_high)
   );

   // Watchdog request into the same stretcher as the pin reset
   assign rst_if.fire = fire_reg;
   // Fire pulse blocks the block one cycle before the stretch starts
   assign run_int = rst_if.rst_n && !fire_reg;

   // ------------------------------------------------
   // Bus decode
   // ------------------------------------------------
   // Zero-wait slave; every access completes in its first access cycle
   assign addr_hit = (paddr == `DWRST_WDG_OFFSET);
   assign wr_hit = psel && penable && pwrite && addr_hit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   // Reversed bit mapping between register and counter
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_map
         assign wr_cnt[gi] = pwdata[`DWRST_T_LSB_POS - gi];
         assign rd_map[`DWRST_T_LSB_POS - gi] = cnt_reg[gi];
      end
   endgenerate
   assign wr_cnt[6] = pwdata[`DWRST_SR_POS];
   assign rd_map[`DWRST_SR_POS] = cnt_reg[6];
   assign rd_map[`DWRST_CTL_POS] = active;

   // Activation: hardware option forces it, else the sticky bit
   assign active = OPT_HW_ACT ? 1'b1 : ctl_reg;
   assign tick = (pre_reg == PRE_W'(PRESCALE - 1));

   // ------------------------------------------------
   // Counter, prescaler, activation, reset request
   // ------------------------------------------------
   always_comb
   begin
      cnt_next = cnt_reg;
      pre_next = pre_reg;
      ctl_next = ctl_reg;
      fire_next = 1'b0;
      if (!run_int)
      begin
         // Any internal reset restores fe (ff with the hardware option) and clears the sticky activate bit
         cnt_next = `DWRST_CNT_RESET;
         pre_next = '0;
         ctl_next = 1'b0;
      end
      else if (wr_hit)
      begin
         cnt_next = wr_cnt;
         pre_next = '0;
         ctl_next = ctl_reg | pwdata[`DWRST_CTL_POS];
         fire_next = !pwdata[`DWRST_SR_POS];
      end
      else if (pwr_reg != PWR_STOP)
      begin
         // Frozen only in true stop mode
         if (tick)
         begin
            pre_next = '0;
            cnt_next = cnt_reg - 7'h01;
            // Bit 6 falling ends the period; only armed counters fire
            fire_next = active && (cnt_reg == `DWRST_CNT_EXPIRE);
         end
         else
         begin
            pre_next = pre_reg + PRE_W'(1);
         end
      end
   end

   // ------------------------------------------------
   // Power state
   // ------------------------------------------------
   always_comb
   begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         PWR_RUN:
         begin
            if (stop_req)
            begin
               if (!active)
               begin
                  pwr_next = PWR_STOP;
               end
               else if (!OPT_EXT_STOP)
               begin
                  pwr_next = PWR_WAIT;
               end
               else if (nmi_high)
               begin
                  pwr_next = PWR_STOP;
               end
               else
               begin
                  pwr_next = PWR_WAIT;
               end
            end
            else if (wait_req)
            begin
               pwr_next = PWR_WAIT;
            end
         end
         PWR_WAIT, PWR_STOP:
         begin
            if (wake_irq)
            begin
               pwr_next = PWR_RUN;
            end
         end
         default:
         begin
            pwr_next = PWR_RUN;
         end
      endcase
      if (!run_int)
      begin
         pwr_next = PWR_RUN;
      end
   end

   // Read data captured in the setup phase, stable in access
   always_comb
   begin
      rd_next = rd_reg;
      if (psel && !penable)
      begin
         rd_next = (addr_hit && !pwrite) ? {24'h0, rd_map} : 32'h0;
      end
   end

   // ------------------------------------------------
   // State registers
   // ------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg <= `DWRST_CNT_RESET;
         pre_reg <= '0;
         ctl_reg <= 1'b0;
         fire_reg <= 1'b0;
         rd_reg <= 32'h0;
         pwr_reg <= PWR_RUN;
      end
      else
      begin
         cnt_reg <= cnt_next;
         pre_reg <= pre_next;
         ctl_reg <= ctl_next;
         fire_reg <= fire_next;
         rd_reg <= rd_next;
         pwr_reg <= pwr_next;
      end
   end

   assign prdata = rd_reg;
   assign mcu_rst_n = rst_if.rst_n;
   assign wdg_active = active;
   assign pwr_state = pwr_reg;

   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_fire;
      fire_reg;
   endsequence

   sequence s_held;
      !mcu_rst_n [*8];
   endsequence

   soft_reset_a: assert property (run_int && wr_hit && !pwdata[1] |=> fire_reg)
      else $error("soft reset write did not fire");

   reset_hold_a: assert property (s_fire |=> s_held)
      else $error("internal reset not held after fire");

   reset_value_a: assert property (!run_int |=> cnt_reg == 7'h7f && !ctl_reg)
      else $error("reset value not restored");

   expire_fire_a: assert property (run_int && !wr_hit && tick && active
      && pwr_reg != PWR_STOP && cnt_reg == 7'h40 |=> fire_reg ##1 !mcu_rst_n)
      else $error("expiry did not reset");

   free_timer_a: assert property (!active && !wr_hit |=> !fire_reg)
      else $error("inactive timer fired");

   act_lock_a: assert property (ctl_reg && run_int |=> ctl_reg)
      else $error("activate bit cleared without reset");

   hw_active_a: assert property (OPT_HW_ACT |-> rd_map[0] && wdg_active)
      else $error("hardware option not active");

   stop_freeze_a: assert property (pwr_reg == PWR_STOP && run_int && !wr_hit
      |=> $stable(cnt_reg) && $stable(pre_reg))
      else $error("counter moved in stop");

   reload_a: assert property (run_int && wr_hit |=> cnt_reg == $past(wr_cnt)
      && pre_reg == '0)
      else $error("write did not load counter");

   stop_as_wait_a: assert property (run_int && pwr_reg == PWR_RUN && stop_req
      && active && !OPT_EXT_STOP |=> pwr_reg == PWR_WAIT)
      else $error("STOP not taken as WAIT");

   wake_run_a: assert property (run_int && pwr_reg != PWR_RUN && wake_irq
      |=> pwr_reg == PWR_RUN)
      else $error("wake did not resume run");
endmodule : dwrst_top
`default_nettype wire

// ---- bench/dwrst_core_model.sv ----
// Processor core model: APB master plus STOP, WAIT and wake strobes.
// Assumes one pclk domain; the testbench calls its tasks.
`timescale 1ns/1ns
`default_nettype none
module dwrst_core_model
(
   input wire logic pclk, // Clock
   output logic psel, // APB select
   output logic penable, // APB access phase
   output logic pwrite, // APB write
   output logic [11:0] paddr, // APB byte address
   output logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   output logic stop_req, // STOP strobe
   output logic wait_req, // WAIT strobe
   output logic wake_irq // Wake strobe
);
   // ------------------------------------------------
   // Idle values
   // ------------------------------------------------
   initial
   begin
      {psel, penable, pwrite, stop_req, wait_req, wake_irq} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // One transfer; reloads keep the soft-reset bit set unless a test asks
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Waits for the slave; only the bench timeout ends a hang
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // Released data is not left looking valid
   endtask : xfer

   // One-cycle strobe: 0 stop, 1 wait, 2 wake
   task automatic pulse(input int k);
      @(posedge pclk);
      stop_req <= (k == 0);
      wait_req <= (k == 1);
      wake_irq <= (k == 2);
      @(posedge pclk);
      {stop_req, wait_req, wake_irq} <= 3'h0;
   endtask : pulse
endmodule : dwrst_core_model
`default_nettype wire

// ---- bench/dwrst_tb_top.sv ----
// Testbench for the watchdog block: software option with stop gating, plus a hardware-option copy.
// Assumes small PRESCALE and STRETCH so the run stays short.
`timescale 1ns/1ns
`default_nettype none
`include "dwrst_cfg.svh"
module dwrst_tb_top;
   import dwrst_pkg::*;
   localparam int PS = 8;
   localparam int ST = 16;
   logic pclk, presetn, nmi_pin, psel, penable, pwrite, pready, pslverr;
   logic stop_req, wait_req, wake_irq, mcu_rst_n, wdg_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   dwrst_pwr_t pwr_state;
   logic [31:0] prdata_hw;
   logic wdg_active_hw;
   dwrst_pwr_t pwr_state_hw;
   int num_errors = 0;
   int compares = 0;

   // ------------------------------------------------
   // Clock, design and core
   // ------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   dwrst_top #(.OPT_EXT_STOP(1'b1), .PRESCALE(PS), .STRETCH(ST)) dut
   (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_req(stop_req),
    .wait_req(wait_req), .wake_irq(wake_irq), .nmi_pin(nmi_pin), .mcu_rst_n(mcu_rst_n),
    .wdg_active(wdg_active), .pwr_state(pwr_state));
   // Hardware option without stop gating; listens to the same bus and strobes
   dwrst_top #(.OPT_HW_ACT(1'b1), .PRESCALE(PS), .STRETCH(ST)) dut_hw
   (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_hw), .pready(), .pslverr(), .stop_req(stop_req),
    .wait_req(wait_req), .wake_irq(wake_irq), .nmi_pin(nmi_pin), .mcu_rst_n(),
    .wdg_active(wdg_active_hw), .pwr_state(pwr_state_hw));
   dwrst_core_model core
   (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_req(stop_req), .wait_req(wait_req),
    .wake_irq(wake_irq));

   // ------------------------------------------------
   // Check and access tasks
   // ------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic experr);
      logic [31:0] q;
      logic e;
      core.xfer(1'b0, a, 32'h0, q, e);
      chk(q, {24'h0, exp}, "read data");
      chk({31'h0, e}, {31'h0, experr}, "read error");
   endtask : rd

   task automatic wr(input logic [7:0] d);
      logic [31:0] q;
      logic e;
      core.xfer(1'b1, `DWRST_WDG_OFFSET, {24'h0, d}, q, e);
   endtask : wr

   // Power state after the strobe has landed
   task automatic st(input dwrst_pwr_t exp);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({30'h0, pwr_state}, {30'h0, exp}, "power state");
   endtask : st

   // Internal reset must stay released for n cycles
   task automatic hold_hi(input int n);
      int bad;
      bad = 0;
      repeat (n)
      begin
         @(negedge pclk);
         bad += (mcu_rst_n !== 1'b1);
      end
      chk(bad, 0, "unexpected reset");
   endtask : hold_hi

   // Reset must fall within lo..hi cycles, stay low ST cycles, then release
   task automatic expire_chk(input int lo, input int hi);
      int n;
      n = 0;
      while (mcu_rst_n === 1'b1 && n < hi)
      begin
         @(negedge pclk);
         n++;
      end
      chk((n >= lo) && (mcu_rst_n === 1'b0), 1, "reset moment");
      n = 0;
      while (mcu_rst_n === 1'b0 && n < 4 * ST)
      begin
         @(negedge pclk);
         n++;
      end
      chk(n, ST, "reset length");
   endtask : expire_chk

   task automatic close_out;
      $display("Errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial
   begin
      presetn = 1'b0;
      nmi_pin = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(mcu_rst_n, 0, "reset held");
      chk(wdg_active_hw, 1, "hw option active");
      expire_chk(0, 1);
      rd(`DWRST_WDG_OFFSET, `DWRST_WDG_RESET, 1'b0);
      chk(prdata_hw, 32'hff, "hw activate bit");
      chk(wdg_active, 0, "inactive after reset");
      rd(12'h0dc, 8'h00, 1'b1);
      // Reversed count bits, load and decrement
      wr(8'h86);
      rd(`DWRST_WDG_OFFSET, 8'h86, 1'b0);
      chk(prdata_hw, 32'h87, "hw activate bit kept");
      repeat (7) @(posedge pclk);
      rd(`DWRST_WDG_OFFSET, 8'h06, 1'b0);
      hold_hi(130 * PS);
      // Stop and wait while inactive
      core.pulse(0);
      st(PWR_STOP);
      chk({30'h0, pwr_state_hw}, {30'h0, PWR_WAIT}, "hw stop as wait");
      core.pulse(2);
      st(PWR_RUN);
      core.pulse(1);
      st(PWR_WAIT);
      core.pulse(2);
      st(PWR_RUN);
      // Activation is sticky
      wr(8'h07);
      @(negedge pclk);
      chk(wdg_active, 1, "activated");
      wr(8'hfe);
      rd(`DWRST_WDG_OFFSET, 8'hff, 1'b0);
      core.pulse(0);
      st(PWR_WAIT);
      core.pulse(2);
      nmi_pin <= 1'b1;
      st(PWR_RUN);
      repeat (6) @(posedge pclk);
      core.pulse(0);
      st(PWR_STOP);
      hold_hi(700);
      core.pulse(2);
      st(PWR_RUN);
      expire_chk(1, 600);
      chk(wdg_active, 0, "inactive after reset");
      rd(`DWRST_WDG_OFFSET, `DWRST_WDG_RESET, 1'b0);
      // Shortest period, reset within PS-1 to PS+6 cycles
      wr(8'h03);
      expire_chk(PS - 1, PS + 6);
      // Soft reset bit cleared
      wr(8'hfc);
      expire_chk(0, 4);
      close_out();
   end

   // Hang guard
   initial
   begin
      #200000;
      num_errors++;
      close_out();
   end
endmodule : dwrst_tb_top
`default_nettype wire
